// file: pkg/serial_status_pkg.sv
// Package with register map and constants of the serial status flag block
package serial_status_pkg;

    localparam logic [11:0] status_reg_off = 12'h000;
    localparam logic [11:0] control_reg_off = 12'h004;
    localparam logic [11:0] tx_data_reg_off = 12'h008;
    localparam logic [11:0] rx_data_reg_off = 12'h00C;

    localparam logic [7:0] status_reset_val = 8'h84;
    localparam logic [7:0] data_reset_val = 8'h00;

    localparam int tx_empty_pos = 7;
    localparam int rx_full_pos = 6;
    localparam int overrun_pos = 5;
    localparam int framing_pos = 4;
    localparam int parity_pos = 3;
    localparam int tx_done_pos = 2;
    localparam int rx_mp_pos = 1;
    localparam int tx_mp_pos = 0;

    localparam int tx_enable_pos = 0;
    localparam int rx_enable_pos = 1;
    localparam int sync_mode_pos = 2;
    localparam int mp_format_pos = 3;
    localparam int parity_odd_pos = 4;
    localparam int parity_en_pos = 5;

endpackage : serial_status_pkg

// file: verilog/serial_status_flag_logic.sv
// Status flag logic of a serial channel with an APB register slave
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Status reads 0x84 after reset or standby
// - Software clears error and buffer flags only by read-then-0
// - Transmit-end and received mp bit are read-only
// - Tx-empty sets on load, tx disable, reset
// - Tx-empty clears by software or DMA write
// - Rx-full sets on error-free received character
// - Rx-full clears on reset, software, DMA read
// - Errors or rx disable keep rx data, rx-full
// - Overrun when rx-full set; new character discarded
// - Errors suspend receive; sync mode also transmit
// - Framing error on first stop bit low
// - Framing/parity error stores data, no rx-full
// - Parity error on count mismatch with odd select
// - Rx disable keeps error flags
// - Tx-end sets on last bit with empty, disable, reset
// - Tx-end clears with tx-empty clear or DMA write
// - Received mp bit captured in async mp format
// - Rx disable holds received mp bit
// - Tx mp bit sent only in async mp format
module serial_status_flag_logic
    import serial_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic standby,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_load,
    output logic [7:0] tx_load_data,
    output logic tx_load_mp_bit,
    output logic tx_mp_bit_used,
    input wire logic tx_last_bit,
    input wire logic rx_done,
    input wire logic [7:0] rx_shift_data,
    input wire logic rx_parity_bit,
    input wire logic rx_stop_bit,
    input wire logic rx_mp_in,
    input wire logic dma_tx_write,
    input wire logic [7:0] dma_tx_data,
    input wire logic dma_rx_read,
    output logic rx_allowed,
    output logic tx_allowed,
    output logic tx_enable,
    output logic rx_enable,
    output logic sync_mode,
    output logic [7:0] rx_data,
    output logic [7:0] status
);

    logic [7:0] status_q;
    logic [5:0] control_q;
    logic [7:0] tx_data_q;
    logic [7:0] rx_data_q;
    logic [7:0] seen_one_q;
    logic tx_enable_q;
    logic [31:0] prdata_q;

    logic wr_acc;
    logic rd_acc;
    logic status_wr;
    logic status_rd;
    logic [7:0] sw_clear;
    logic rx_ok;
    logic frame_err;
    logic parity_err;
    logic any_err;
    logic tx_dis;
    logic parity_odd;
    logic mp_format;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign status_wr = wr_acc && (paddr == status_reg_off) && pstrb[0];
    assign status_rd = rd_acc && (paddr == status_reg_off);
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_q;

    assign tx_enable = control_q[tx_enable_pos];
    assign rx_enable = control_q[rx_enable_pos];
    assign sync_mode = control_q[sync_mode_pos];
    assign mp_format = control_q[mp_format_pos];
    assign parity_odd = control_q[parity_odd_pos];
    assign status = status_q;
    assign rx_data = rx_data_q;
    assign tx_load_data = tx_data_q;
    assign tx_dis = tx_enable_q && !tx_enable;

    // Software clear of a flag: write 0 after it was read as 1
    always_comb begin
        sw_clear = 8'h00;
        for (int i = 3; i < 8; i++) begin
            sw_clear[i] = status_wr && !pwdata[i] && seen_one_q[i];
        end
    end

    // Receive checks
    assign any_err = status_q[overrun_pos] || status_q[framing_pos] ||
        status_q[parity_pos];
    assign rx_allowed = rx_enable && !any_err;
    assign tx_allowed = tx_enable && !(sync_mode && any_err);
    assign frame_err = !sync_mode && !rx_stop_bit;
    assign parity_err = !sync_mode && control_q[parity_en_pos] &&
        ((^rx_shift_data ^ rx_parity_bit) != parity_odd);
    assign rx_ok = rx_done && rx_allowed;

    // Multiprocessor bit goes with transmit data only in async mp format
    assign tx_mp_bit_used = !sync_mode && mp_format && tx_enable;
    assign tx_load_mp_bit = tx_mp_bit_used && status_q[tx_mp_pos];

    // Record which flags software has read as 1
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seen_one_q <= 8'h00;
        end else if (standby) begin
            seen_one_q <= 8'h00;
        end else begin
            for (int i = 3; i < 8; i++) begin
                if (status_rd && status_q[i]) begin
                    seen_one_q[i] <= 1'b1;
                end else if (sw_clear[i] || !status_q[i]) begin
                    seen_one_q[i] <= 1'b0;
                end
            end
        end
    end

    // Status flags
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_q <= status_reset_val;
        end else if (standby) begin
            status_q <= status_reset_val;
        end else begin
            // Transmit-empty: set wins over clear
            if (tx_load || tx_dis) begin
                status_q[tx_empty_pos] <= 1'b1;
            end else if (sw_clear[tx_empty_pos] || dma_tx_write) begin
                status_q[tx_empty_pos] <= 1'b0;
            end
            // Transmit-end follows the transmit-empty clear
            if ((tx_last_bit && status_q[tx_empty_pos]) || tx_dis) begin
                status_q[tx_done_pos] <= 1'b1;
            end else if (sw_clear[tx_empty_pos] || dma_tx_write) begin
                status_q[tx_done_pos] <= 1'b0;
            end
            // Receive-full
            if (rx_ok && !status_q[rx_full_pos] && !frame_err &&
                !parity_err) begin
                status_q[rx_full_pos] <= 1'b1;
            end else if (sw_clear[rx_full_pos] || dma_rx_read) begin
                status_q[rx_full_pos] <= 1'b0;
            end
            if (rx_ok && status_q[rx_full_pos]) begin
                status_q[overrun_pos] <= 1'b1;
            end else if (sw_clear[overrun_pos]) begin
                status_q[overrun_pos] <= 1'b0;
            end
            if (rx_ok && !status_q[rx_full_pos] && frame_err) begin
                status_q[framing_pos] <= 1'b1;
            end else if (sw_clear[framing_pos]) begin
                status_q[framing_pos] <= 1'b0;
            end
            if (rx_ok && !status_q[rx_full_pos] && parity_err) begin
                status_q[parity_pos] <= 1'b1;
            end else if (sw_clear[parity_pos]) begin
                status_q[parity_pos] <= 1'b0;
            end
            if (rx_ok && !sync_mode && mp_format) begin
                status_q[rx_mp_pos] <= rx_mp_in;
            end
            if (status_wr) begin
                status_q[tx_mp_pos] <= pwdata[tx_mp_pos];
            end
        end
    end

    // Receive data register keeps old data on overrun
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_data_q <= data_reset_val;
        end else if (rx_ok && !status_q[rx_full_pos]) begin
            rx_data_q <= rx_shift_data;
        end
    end

    // Control and transmit data registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            control_q <= 6'h00;
            tx_data_q <= data_reset_val;
            tx_enable_q <= 1'b0;
        end else begin
            tx_enable_q <= tx_enable;
            if (wr_acc && paddr == control_reg_off && pstrb[0]) begin
                control_q <= pwdata[5:0];
            end
            if (dma_tx_write) begin
                tx_data_q <= dma_tx_data;
            end else if (wr_acc && paddr == tx_data_reg_off && pstrb[0]) begin
                tx_data_q <= pwdata[7:0];
            end
        end
    end

    // APB read data, registered in the setup cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                status_reg_off: prdata_q <= {24'h00_0000, status_q};
                control_reg_off: prdata_q <= {26'h000_0000, control_q};
                tx_data_reg_off: prdata_q <= {24'h00_0000, tx_data_q};
                rx_data_reg_off: prdata_q <= {24'h00_0000, rx_data_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    a_reset_value: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(standby) |=> status_q == status_reset_val)
        else $error("status not 0x84 after standby");

    a_standby_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        standby |=> status_q == status_reset_val)
        else $error("status not held during standby");

    a_no_set_write: assert property (
        @(posedge core_clk) disable iff (rst)
        (status_wr && !standby && !rx_done && !status_q[rx_full_pos])
        |=> !status_q[rx_full_pos])
        else $error("rx full set by write");

    a_ro_bits: assert property (
        @(posedge core_clk) disable iff (rst)
        (status_wr && !rx_ok && !tx_last_bit && !tx_dis && !standby &&
        !sw_clear[tx_empty_pos] && !dma_tx_write) |=> $stable(status_q[2:1]))
        else $error("read-only status bits written");

    a_tx_empty_set: assert property (
        @(posedge core_clk) disable iff (rst)
        tx_load |=> status_q[tx_empty_pos])
        else $error("tx empty not set on load");

    a_tx_disable: assert property (
        @(posedge core_clk) disable iff (rst)
        tx_dis |=> status_q[tx_empty_pos] && status_q[tx_done_pos])
        else $error("tx flags not set on tx disable");

    a_dma_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (dma_tx_write && !tx_load && !tx_dis && !standby) |=>
        !status_q[tx_empty_pos] && !status_q[tx_done_pos])
        else $error("dma write did not clear tx flags");

    a_sw_tx_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (sw_clear[tx_empty_pos] && !tx_load && !tx_dis && !standby) |=>
        !status_q[tx_empty_pos] && !status_q[tx_done_pos])
        else $error("software clear missed tx flags");

    a_rx_full_set: assert property (
        @(posedge core_clk) disable iff (rst)
        (rx_ok && !status_q[rx_full_pos] && !frame_err && !parity_err &&
        !standby) |=> status_q[rx_full_pos] && rx_data_q == $past(rx_shift_data))
        else $error("rx full not set on good character");

    a_rx_full_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (dma_rx_read && !rx_ok && !standby) |=> !status_q[rx_full_pos])
        else $error("dma read did not clear rx full");

    a_rx_data_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        !rx_ok |=> $stable(rx_data_q))
        else $error("rx data changed without a character");

    a_overrun_keep: assert property (
        @(posedge core_clk) disable iff (rst)
        (rx_ok && status_q[rx_full_pos] && !standby) |=>
        status_q[overrun_pos] && $stable(rx_data_q))
        else $error("overrun not flagged");

    a_err_block: assert property (
        @(posedge core_clk) disable iff (rst)
        any_err |-> !rx_allowed)
        else $error("receive allowed with error");

    a_tx_suspend: assert property (
        @(posedge core_clk) disable iff (rst)
        (sync_mode && any_err) |-> !tx_allowed)
        else $error("sync transmit allowed with error");

    a_frame_no_full: assert property (
        @(posedge core_clk) disable iff (rst)
        (rx_ok && frame_err && !status_q[rx_full_pos] && !standby) |=>
        status_q[framing_pos] && !status_q[rx_full_pos])
        else $error("framing error handling wrong");

    a_parity_set: assert property (
        @(posedge core_clk) disable iff (rst)
        (rx_ok && parity_err && !status_q[rx_full_pos] && !standby) |=>
        status_q[parity_pos] && !status_q[rx_full_pos])
        else $error("parity error handling wrong");

    a_err_keep: assert property (
        @(posedge core_clk) disable iff (rst)
        (!rx_enable && !sw_clear[overrun_pos] && !standby) |=>
        $stable(status_q[overrun_pos]))
        else $error("overrun changed while rx disabled");

    a_tx_complete_flag_set: assert property (
        @(posedge core_clk) disable iff (rst)
        (tx_last_bit && status_q[tx_empty_pos]) |=> status_q[tx_done_pos])
        else $error("tx end not set");

    a_rx_mp_capture: assert property (
        @(posedge core_clk) disable iff (rst)
        (rx_ok && !sync_mode && mp_format && !standby) |=>
        status_q[rx_mp_pos] == $past(rx_mp_in))
        else $error("received mp bit not captured");

    a_rx_mp_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        (!rx_enable && !standby) |=> $stable(status_q[rx_mp_pos]))
        else $error("received mp bit changed while rx disabled");

    a_tx_mp_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        (sync_mode || !mp_format) |-> !tx_mp_bit_used && !tx_load_mp_bit)
        else $error("tx mp bit used outside async mp format");

    a_clear_needs_read: assert property (
        @(posedge core_clk) disable iff (rst)
        (status_wr && !pwdata[rx_full_pos] && !seen_one_q[rx_full_pos] &&
        status_q[rx_full_pos] && !dma_rx_read && !standby) |=>
        status_q[rx_full_pos])
        else $error("rx full cleared without prior read");

    a_set_beats_clear: assert property (
        @(posedge core_clk) disable iff (rst)
        (tx_load && sw_clear[tx_empty_pos]) |=> status_q[tx_empty_pos])
        else $error("clear won over tx empty set");

endmodule : serial_status_flag_logic

`default_nettype wire

// file: testbench/line_model.sv
// Far-side station model: shift engine events fed to the flag logic
`timescale 1ns/1ps
`default_nettype none
module line_model (
    input wire logic core_clk,
    output logic tx_load,
    output logic tx_last_bit,
    output logic rx_done,
    output logic [7:0] rx_shift_data,
    output logic rx_parity_bit,
    output logic rx_stop_bit,
    output logic rx_mp_in
);
    initial begin
        {tx_load, tx_last_bit, rx_done} = 3'h0;
        {rx_shift_data, rx_parity_bit, rx_stop_bit, rx_mp_in} = 11'h000;
    end
    // One character; fields are valid only with the done pulse
    task rx_char(input logic [7:0] d, input logic p, s, m);
        rx_done <= 1'b1;
        {rx_shift_data, rx_parity_bit, rx_mp_in} <= {d, p, m};
        rx_stop_bit <= s;
        @(posedge core_clk);
        // Fields no longer valid: show the inverse, not the old value
        rx_done <= 1'b0;
        {rx_shift_data, rx_parity_bit, rx_stop_bit} <= ~{d, p, s};
        rx_mp_in <= ~m;
        @(posedge core_clk);
    endtask : rx_char
    task tx_event(input logic last);
        {tx_last_bit, tx_load} <= {last, ~last};
        @(posedge core_clk);
        {tx_last_bit, tx_load} <= 2'h0;
        @(posedge core_clk);
    endtask : tx_event
endmodule : line_model
`default_nettype wire

// file: testbench/serial_status_flag_logic_tb_top.sv
// Self-checking bench of the serial status flag logic
`timescale 1ns/1ps
`default_nettype none
module serial_status_flag_logic_tb_top;
    import serial_status_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, standby = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, tx_load, tx_last_bit, rx_done, rx_parity_bit, rx_stop_bit;
    logic rx_mp_in, tx_mp_bit_used, tx_load_mp_bit, rx_allowed, tx_allowed;
    logic dma_tx_write = 1'b0, dma_rx_read = 1'b0;
    logic [7:0] dma_tx_data = 8'h00, rx_shift_data, tx_load_data, rx_data;
    logic [7:0] q, d, d1;
    logic m, odd, tx_en, rx_en, sync_on;
    logic [7:0] status_img;
    int mismatches = 0, total_checks = 0;
    always #4 core_clk = ~core_clk;
    serial_status_flag_logic u_serial_status_flag_logic (
        .core_clk(core_clk), .rst(rst), .standby(standby), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(),
        .tx_load(tx_load), .tx_load_data(tx_load_data),
        .tx_load_mp_bit(tx_load_mp_bit), .tx_mp_bit_used(tx_mp_bit_used),
        .tx_last_bit(tx_last_bit), .rx_done(rx_done),
        .rx_shift_data(rx_shift_data), .rx_parity_bit(rx_parity_bit),
        .rx_stop_bit(rx_stop_bit), .rx_mp_in(rx_mp_in),
        .dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data),
        .dma_rx_read(dma_rx_read), .rx_allowed(rx_allowed),
        .tx_allowed(tx_allowed), .tx_enable(tx_en), .rx_enable(rx_en),
        .sync_mode(sync_on), .rx_data(rx_data), .status(status_img));
    line_model u_line_model (
        .core_clk(core_clk), .tx_load(tx_load), .tx_last_bit(tx_last_bit),
        .rx_done(rx_done), .rx_shift_data(rx_shift_data),
        .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit),
        .rx_mp_in(rx_mp_in));
    task test_done;
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        {psel, pwrite, paddr} <= {1'b1, w, a};
        pwdata <= {24'h00_0000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata[7:0];
        {psel, penable} <= 2'h0;
        if (pready !== 1'b1) begin
            mismatches++;
            test_done;
        end
        @(posedge core_clk);
    endtask : apb
    task st(input logic [7:0] e);
        apb(1'b0, status_reg_off, 8'h00);
        chk("status", e, q);
    endtask : st
    task dma(input logic w, input logic [7:0] v);
        {dma_tx_write, dma_rx_read, dma_tx_data} <= {w, ~w, v};
        @(posedge core_clk);
        {dma_tx_write, dma_rx_read, dma_tx_data} <= {2'h0, ~v};
        @(posedge core_clk);
    endtask : dma
    task rx(input logic [7:0] v, input logic p, s);
        u_line_model.rx_char(v, p, s, 1'b0);
    endtask : rx
    function automatic logic par(input logic [7:0] v, input logic o, g);
        return (^v) ^ o ^ ~g;
    endfunction : par
    initial begin
        void'($urandom(8));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b1, status_reg_off, 8'h00);
        st(8'h84);
        apb(1'b1, status_reg_off, 8'h00);
        st(8'h00);
        apb(1'b1, status_reg_off, 8'hff);
        st(8'h01);
        $display("test clearing done");
        apb(1'b1, control_reg_off, 8'h0b);
        chk("tx_mp", 8'h03, {6'h00, tx_mp_bit_used, tx_load_mp_bit});
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            m = 1'($urandom);
            u_line_model.rx_char(d, 1'b0, 1'b1, m);
            st({6'h10, m, 1'b1});
            chk("rx_data", d, rx_data);
            dma(1'b0, 8'h00);
            st({6'h00, m, 1'b1});
        end
        d1 = 8'($urandom);
        rx(d1, 1'b0, 1'b1);
        rx(~d1, 1'b0, 1'b1);
        st(8'h61);
        rx(d1 ^ 8'h5a, 1'b0, 1'b1);
        chk("rx_data", d1, rx_data);
        chk("rx_allowed", 8'h00, {7'h00, rx_allowed});
        apb(1'b1, status_reg_off, 8'h01);
        rx(~d1, 1'b0, 1'b0);
        st(8'h11);
        chk("rx_data", ~d1, rx_data);
        apb(1'b1, control_reg_off, 8'h09);
        st(8'h11);
        apb(1'b1, status_reg_off, 8'h01);
        $display("test receive done");
        odd = 1'($urandom);
        apb(1'b1, control_reg_off, {3'h1, odd, 4'h3});
        chk("tx_mp", 8'h00, {7'h00, tx_mp_bit_used});
        rx(d1, par(d1, odd, 1'b0), 1'b1);
        st(8'h09);
        apb(1'b1, status_reg_off, 8'h01);
        rx(~d1, par(~d1, odd, 1'b1), 1'b1);
        st(8'h41);
        dma(1'b0, 8'h00);
        $display("test parity done");
        dma(1'b1, d1);
        chk("tx_data", d1, tx_load_data);
        u_line_model.tx_event(1'b0);
        st(8'h81);
        u_line_model.tx_event(1'b1);
        st(8'h85);
        dma(1'b1, ~d1);
        st(8'h01);
        apb(1'b1, control_reg_off, 8'h02);
        st(8'h85);
        apb(1'b1, control_reg_off, 8'h07);
        chk("modes", 8'h07, {5'h00, sync_on, rx_en, tx_en});
        rx(d1, 1'b0, 1'b1);
        rx(d1, 1'b0, 1'b1);
        chk("tx_allowed", 8'h00, {7'h00, tx_allowed});
        standby <= 1'b1;
        repeat (2) @(posedge core_clk);
        standby <= 1'b0;
        @(posedge core_clk);
        st(8'h84);
        chk("status_img", 8'h84, status_img);
        apb(1'b0, 12'h010, 8'h00);
        chk("unmapped", 8'h00, q);
        $display("test transmit done");
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        test_done;
    end
endmodule : serial_status_flag_logic_tb_top
`default_nettype wire
